// ### fifo_ctl_defines.svh
// Constants for the dual-clock FIFO port control block
`ifndef FIFO_CTL_DEFINES_SVH
`define FIFO_CTL_DEFINES_SVH
`define DATA_W 36
`define HALF_W 18
`define BYTE_W 9
`define PAY_W 8
`define LANES 4
`define DEPTH_DEF 1024
`define AW_DEF 10
`define OFF_SHIFT 3
`endif

// ### fifo_ctl_pkg.sv
// Types shared by the dual-clock FIFO port control block
package fifo_ctl_pkg;
   typedef enum logic [1:0] {W36, W18, W9} width_t;
   typedef struct packed {
      logic wclk;
      logic rclk;
      logic wen_n;
      logic ren_n;
      logic oe_n;
      logic offset_load_n;
      logic serial_shift_enable_n;
      logic mode_select_serial_in;
      logic master_reset_n;
   } pin_ctl_t;
   typedef struct packed {
      logic flag_select_0;
      logic flag_select_1;
      logic bus_match_select;
      logic input_width_sel;
      logic output_width_sel;
      logic byte_order_select;
      logic prog_flag_timing_mode;
      logic parity_position_mode;
      logic async_write_select_n;
      logic async_read_select_n;
   } pin_cfg_t;
   typedef struct packed {
      pin_ctl_t c;
      pin_cfg_t g;
      logic [35:0] d;
   } pin_all_t;
   typedef struct packed {
      logic fwft;
      logic serial_prog;
      logic big_endian;
      logic pfm_sync;
      logic interspersed;
      logic async_wr;
      logic async_rd;
      width_t in_w;
      width_t out_w;
      logic [2:0] off_sel;
   } cfg_t;
   typedef struct packed {
      logic full_flag_n;
      logic empty_flag_n;
      logic almost_full_flag_n;
      logic almost_empty_flag_n;
      logic half_full_flag_n;
   } flags_t;
endpackage

// ### dual_clock_fifo_port_control.sv
// Dual-clock 36-bit FIFO with port, flag and offset control
//
// The implementer's own choices: the register offsets.
`timescale 1ns/100ps
`include "fifo_ctl_defines.svh"
module dual_clock_fifo_port_control #(
   parameter int DEPTH = `DEPTH_DEF,
   parameter int AW = `AW_DEF
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Pins from the host
   input wire fifo_ctl_pkg::pin_ctl_t ctl_in,
   input wire fifo_ctl_pkg::pin_cfg_t cfg_in,
   input wire logic [`DATA_W-1:0] data_in_bus_in,
   // Data and flags to the host
   output logic [`DATA_W-1:0] data_out_bus_out,
   output logic data_out_oe_out,
   output fifo_ctl_pkg::flags_t flags_out
);
   import fifo_ctl_pkg::*;

   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_C = (AW+1)'(DEPTH / 2);

   function automatic int part_w(width_t w);
      unique case (w)
         W36: part_w = `DATA_W;
         W18: part_w = `HALF_W;
         W9: part_w = `BYTE_W;
      endcase
   endfunction

   function automatic logic [`DATA_W-1:0] lane_mask(width_t w);
      lane_mask = {`DATA_W{1'b1}} >> (`DATA_W - part_w(w));
   endfunction

   pin_all_t raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_d_reg;
   cfg_t cfg_reg, cfg_next;
   logic [`DATA_W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg, rd_ptr_reg, rptr_w1_reg, rptr_w2_reg, wptr_r1_reg, wptr_r2_reg;
   logic [AW:0] wr_ptr_next, rd_ptr_next, words_w, words_r;
   logic [`DATA_W-1:0] acc_reg, acc_next, sh_reg, pop_word, stripped;
   logic [1:0] in_idx_reg, out_left_reg, last_in, last_out;
   logic out_valid_reg, out_valid_next, off_wr_sel_reg, off_rd_sel_reg;
   logic [AW-1:0] empty_off_reg, full_off_reg;
   logic wclk_rise, rclk_rise, mrs_n, ld_on, wen_ok, ren_ok, full_w, avail_r;
   logic in_take, push, true_read, pop, shift_out;

   // Three-stage pin sampling; a bit moves once stages two and three agree
   assign raw = {ctl_in, cfg_in, data_in_bus_in};
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         pin_reg <= '0;
         pin_d_reg <= '0;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);
         pin_d_reg <= pin_reg;
      end
   end

   assign wclk_rise = pin_reg.c.wclk & ~pin_d_reg.c.wclk;
   assign rclk_rise = pin_reg.c.rclk & ~pin_d_reg.c.rclk;
   assign mrs_n = pin_reg.c.master_reset_n;
   assign ld_on = ~pin_reg.c.offset_load_n;

   // Configuration decoded from pins held during master reset
   always_comb begin
      cfg_next = '0;
      cfg_next.async_wr = ~pin_reg.g.async_write_select_n;
      cfg_next.async_rd = ~pin_reg.g.async_read_select_n;
      // Async ports cannot run fall-through
      cfg_next.fwft = pin_reg.c.mode_select_serial_in & ~cfg_next.async_wr & ~cfg_next.async_rd;
      cfg_next.serial_prog = pin_reg.c.offset_load_n;
      cfg_next.off_sel = {pin_reg.c.offset_load_n, pin_reg.g.flag_select_1,
                          pin_reg.g.flag_select_0};
      cfg_next.big_endian = ~pin_reg.g.byte_order_select;
      cfg_next.pfm_sync = pin_reg.g.prog_flag_timing_mode;
      cfg_next.interspersed = pin_reg.g.parity_position_mode;
      cfg_next.in_w = W36;
      cfg_next.out_w = W36;
      if (pin_reg.g.bus_match_select) begin
         unique case ({pin_reg.g.input_width_sel, pin_reg.g.output_width_sel})
            2'h0: cfg_next.out_w = W18;
            2'h1: cfg_next.out_w = W9;
            2'h2: cfg_next.in_w = W18;
            2'h3: cfg_next.in_w = W9;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_reg <= '0;
      end else if (!mrs_n) begin
         cfg_reg <= cfg_next;
      end
   end

   // Write side
   assign last_in = 2'((`DATA_W / part_w(cfg_reg.in_w)) - 1);
   assign words_w = wr_ptr_next - rptr_w1_reg;
   assign full_w = (wr_ptr_reg - rptr_w2_reg) == DEPTH_C;
   assign wen_ok = ~pin_reg.c.wen_n | cfg_reg.async_wr;
   assign in_take = wclk_rise & mrs_n & wen_ok & ~full_w & ~ld_on;
   assign push = in_take & (in_idx_reg == last_in);
   assign wr_ptr_next = wr_ptr_reg + (AW+1)'(push);

   // Narrow writes gather into one long word in the chosen byte order
   always_comb begin
      acc_next = pin_reg.d & lane_mask(cfg_reg.in_w);
      if (cfg_reg.big_endian) begin
         acc_next = (acc_reg << part_w(cfg_reg.in_w)) | acc_next;
      end else begin
         acc_next = (acc_reg >> part_w(cfg_reg.in_w))
                    | (acc_next << (`DATA_W - part_w(cfg_reg.in_w)));
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= '0;
         in_idx_reg <= '0;
         acc_reg <= '0;
         rptr_w1_reg <= '0;
         rptr_w2_reg <= '0;
      end else if (!mrs_n) begin
         wr_ptr_reg <= '0;
         in_idx_reg <= '0;
         acc_reg <= '0;
         rptr_w1_reg <= '0;
         rptr_w2_reg <= '0;
      end else begin
         if (in_take) begin
            acc_reg <= acc_next;
            in_idx_reg <= push ? 2'h0 : in_idx_reg + 2'h1;
         end
         wr_ptr_reg <= wr_ptr_next;
         // Read pointer crosses in two write clock steps
         if (wclk_rise) begin
            rptr_w1_reg <= rd_ptr_reg;
            rptr_w2_reg <= rptr_w1_reg;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= acc_next;
      end
   end

   // Read side
   assign last_out = 2'((`DATA_W / part_w(cfg_reg.out_w)) - 1);
   assign avail_r = rd_ptr_reg != wptr_r2_reg;
   assign ren_ok = ~pin_reg.c.ren_n | cfg_reg.async_rd;
   assign true_read = rclk_rise & mrs_n & ren_ok & ~ld_on;
   assign shift_out = true_read & (out_left_reg != 2'h0) & (out_valid_reg | ~cfg_reg.fwft);
   // Fall-through refills an empty output without a read enable
   assign pop = rclk_rise & mrs_n & ~ld_on & avail_r & (out_left_reg == 2'h0)
                & (cfg_reg.fwft ? (~out_valid_reg | ren_ok) : ren_ok);
   assign rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
   assign words_r = wptr_r1_reg - rd_ptr_next;
   assign pop_word = mem[rd_ptr_reg[AW-1:0]];

   always_comb begin
      out_valid_next = out_valid_reg;
      if (pop) begin
         out_valid_next = 1'b1;
      end else if (true_read & ~shift_out) begin
         out_valid_next = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_ptr_reg <= '0;
         wptr_r1_reg <= '0;
         wptr_r2_reg <= '0;
         out_valid_reg <= 1'b0;
         out_left_reg <= '0;
         sh_reg <= '0;
         data_out_bus_out <= '0;
         off_rd_sel_reg <= 1'b0;
      end else if (!mrs_n) begin
         rd_ptr_reg <= '0;
         wptr_r1_reg <= '0;
         wptr_r2_reg <= '0;
         out_valid_reg <= 1'b0;
         out_left_reg <= '0;
         sh_reg <= '0;
         data_out_bus_out <= '0;
         off_rd_sel_reg <= 1'b0;
      end else begin
         rd_ptr_reg <= rd_ptr_next;
         out_valid_reg <= out_valid_next;
         // Write pointer crosses in two read clock steps
         if (rclk_rise) begin
            wptr_r1_reg <= wr_ptr_reg;
            wptr_r2_reg <= wptr_r1_reg;
         end
         if (!ld_on) begin
            off_rd_sel_reg <= 1'b0;
         end
         if (rclk_rise & ld_on & ren_ok) begin
            data_out_bus_out <= `DATA_W'(off_rd_sel_reg ? full_off_reg : empty_off_reg);
            off_rd_sel_reg <= ~off_rd_sel_reg;
         end else if (pop) begin
            data_out_bus_out <= cfg_reg.big_endian
               ? (pop_word >> (`DATA_W - part_w(cfg_reg.out_w))) & lane_mask(cfg_reg.out_w)
               : pop_word & lane_mask(cfg_reg.out_w);
            sh_reg <= cfg_reg.big_endian ? pop_word << part_w(cfg_reg.out_w)
                                         : pop_word >> part_w(cfg_reg.out_w);
            out_left_reg <= last_out;
         end else if (shift_out) begin
            data_out_bus_out <= cfg_reg.big_endian
               ? (sh_reg >> (`DATA_W - part_w(cfg_reg.out_w))) & lane_mask(cfg_reg.out_w)
               : sh_reg & lane_mask(cfg_reg.out_w);
            sh_reg <= cfg_reg.big_endian ? sh_reg << part_w(cfg_reg.out_w)
                                         : sh_reg >> part_w(cfg_reg.out_w);
            out_left_reg <= out_left_reg - 2'h1;
         end
      end
   end

   // Output enable follows the sampled pin, so it lags by the sampler depth
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_out_oe_out <= 1'b0;
      end else begin
         data_out_oe_out <= ~pin_reg.c.oe_n;
      end
   end

   // Offset registers
   for (genvar i = 0; i < `LANES; i++) begin : g_strip
      assign stripped[i*`PAY_W +: `PAY_W] = cfg_reg.interspersed
         ? pin_reg.d[i*`BYTE_W +: `PAY_W] : pin_reg.d[i*`PAY_W +: `PAY_W];
   end
   assign stripped[`DATA_W-1:`LANES*`PAY_W] = '0;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         empty_off_reg <= '0;
         full_off_reg <= '0;
         off_wr_sel_reg <= 1'b0;
      end else if (!mrs_n) begin
         empty_off_reg <= AW'((1 << (cfg_next.off_sel + `OFF_SHIFT)) - 1);
         full_off_reg <= AW'((1 << (cfg_next.off_sel + `OFF_SHIFT)) - 1);
         off_wr_sel_reg <= 1'b0;
      end else if (!ld_on) begin
         off_wr_sel_reg <= 1'b0;
      end else if (wclk_rise & cfg_reg.serial_prog & ~pin_reg.c.serial_shift_enable_n) begin
         {empty_off_reg, full_off_reg} <= {empty_off_reg[AW-2:0], full_off_reg,
                                           pin_reg.c.mode_select_serial_in};
      end else if (wclk_rise & ~cfg_reg.serial_prog & ~pin_reg.c.wen_n) begin
         if (off_wr_sel_reg) begin
            full_off_reg <= stripped[AW-1:0];
         end else begin
            empty_off_reg <= stripped[AW-1:0];
         end
         off_wr_sel_reg <= ~off_wr_sel_reg;
      end
   end

   // Outside master reset, flags move only on their own clock edges; read edge applied last
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_out <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      end else if (!mrs_n) begin
         flags_out <= '{~cfg_next.fwft, cfg_next.fwft, 1'b1, 1'b0, 1'b1};
      end else begin
         if (wclk_rise) begin
            flags_out.full_flag_n <= cfg_reg.fwft ^ (words_w != DEPTH_C);
            if (words_w > HALF_C) begin
               flags_out.half_full_flag_n <= 1'b0;
            end
            if (cfg_reg.pfm_sync | (words_w >= DEPTH_C - (AW+1)'(full_off_reg))) begin
               flags_out.almost_full_flag_n <= words_w < DEPTH_C - (AW+1)'(full_off_reg);
            end
            if (~cfg_reg.pfm_sync & (words_w > (AW+1)'(empty_off_reg))) begin
               flags_out.almost_empty_flag_n <= 1'b1;
            end
         end
         if (rclk_rise) begin
            flags_out.empty_flag_n <= cfg_reg.fwft ? ~out_valid_next
                                                  : (rd_ptr_next != wptr_r1_reg);
            if (words_r <= HALF_C) begin
               flags_out.half_full_flag_n <= 1'b1;
            end
            if (cfg_reg.pfm_sync | (words_r <= (AW+1)'(empty_off_reg))) begin
               flags_out.almost_empty_flag_n <= words_r > (AW+1)'(empty_off_reg);
            end
            if (~cfg_reg.pfm_sync & (words_r < DEPTH_C - (AW+1)'(full_off_reg))) begin
               flags_out.almost_full_flag_n <= 1'b1;
            end
         end
      end
   end

   // Checks
   property p_no_wen;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wclk_rise & pin_reg.c.wen_n & ~cfg_reg.async_wr |=> wr_ptr_reg == $past(wr_ptr_reg);
   endproperty
   a_no_wen: assert property (p_no_wen) else $error("write without enable");
   property p_full_block;
      @(posedge mclk_in) disable iff (!rst_n_in)
      mrs_n & full_w |=> wr_ptr_reg == $past(wr_ptr_reg);
   endproperty
   a_full_block: assert property (p_full_block) else $error("write while full");
   property p_idle_flags;
      @(posedge mclk_in) disable iff (!rst_n_in)
      ~wclk_rise & ~rclk_rise & mrs_n |=> $stable(flags_out);
   endproperty
   a_idle_flags: assert property (p_idle_flags) else $error("flag moved without edge");
   property p_hf_wlow;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wclk_rise & ~rclk_rise & mrs_n & ~flags_out.half_full_flag_n |=> ~flags_out.half_full_flag_n;
   endproperty
   a_hf_wlow: assert property (p_hf_wlow) else $error("write edge raised half full");
   property p_hf_rhigh;
      @(posedge mclk_in) disable iff (!rst_n_in)
      rclk_rise & ~wclk_rise & mrs_n & flags_out.half_full_flag_n |=> flags_out.half_full_flag_n;
   endproperty
   a_hf_rhigh: assert property (p_hf_rhigh) else $error("read edge lowered half full");
   property p_ren_hold;
      @(posedge mclk_in) disable iff (!rst_n_in)
      rclk_rise & pin_reg.c.ren_n & ~cfg_reg.async_rd & ~cfg_reg.fwft & mrs_n & ~ld_on
      |=> $stable(data_out_bus_out);
   endproperty
   a_ren_hold: assert property (p_ren_hold) else $error("outputs moved without read");
   property p_oe;
      @(posedge mclk_in) disable iff (!rst_n_in)
      pin_reg.c.oe_n |=> ~data_out_oe_out;
   endproperty
   a_oe: assert property (p_oe) else $error("driving while disabled");
   property p_empty_block;
      @(posedge mclk_in) disable iff (!rst_n_in)
      ~cfg_reg.fwft & mrs_n & ~flags_out.empty_flag_n |-> ~avail_r & ~pop;
   endproperty
   a_empty_block: assert property (p_empty_block) else $error("read while empty");
   property p_cfg_hold;
      @(posedge mclk_in) disable iff (!rst_n_in)
      mrs_n & $past(mrs_n) |-> $stable(cfg_reg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
   property p_no_async_fwft;
      @(posedge mclk_in) disable iff (!rst_n_in)
      cfg_reg.async_wr |-> ~cfg_reg.fwft;
   endproperty
   a_no_async_fwft: assert property (p_no_async_fwft) else $error("async with fall-through");
   property p_sen_hold;
      @(posedge mclk_in) disable iff (!rst_n_in)
      mrs_n & pin_reg.c.serial_shift_enable_n & cfg_reg.serial_prog |=> $stable(empty_off_reg);
   endproperty
   a_sen_hold: assert property (p_sen_hold) else $error("offset changed");
endmodule // dual_clock_fifo_port_control

// ### fifo_host_model.sv
// Host-side model driving the buffer's clock, enable, control and data pins
`timescale 1ns/100ps
module fifo_host_model (
   // Clock
   input wire logic mclk_in,
   // Pins to the buffer
   output fifo_ctl_pkg::pin_ctl_t ctl_out,
   output logic [35:0] data_out
);
   import fifo_ctl_pkg::*;
   logic async_hold;
   initial begin
      ctl_out = 9'h06c;
      data_out = '0;
      async_hold = 1'b0;
   end
   // One link clock period: 4 mclk high, 6 low (400 ns)
   task automatic pulse(input logic wr, input logic en_n, input logic [35:0] d);
      @(posedge mclk_in);
      if (wr) begin
         ctl_out.wen_n <= async_hold ? 1'b0 : en_n;
         data_out <= d;
      end else begin
         ctl_out.ren_n <= async_hold ? 1'b0 : en_n;
      end
      @(posedge mclk_in);
      if (wr) ctl_out.wclk <= 1'b1;
      else ctl_out.rclk <= 1'b1;
      repeat (4) @(posedge mclk_in);
      if (wr) ctl_out.wclk <= 1'b0;
      else ctl_out.rclk <= 1'b0;
      repeat (4) @(posedge mclk_in);
      // Released data bus shows no stale word
      if (wr) begin
         ctl_out.wen_n <= ~async_hold;
         data_out <= ~d;
      end else begin
         ctl_out.ren_n <= ~async_hold;
      end
   endtask
   task automatic set_misc(input logic oe_n, input logic ld_n, input logic sen_n,
                           input logic si);
      @(posedge mclk_in);
      ctl_out.oe_n <= oe_n;
      ctl_out.offset_load_n <= ld_n;
      ctl_out.serial_shift_enable_n <= sen_n;
      ctl_out.mode_select_serial_in <= si;
   endtask
   // Async ports need the enables tied low for good
   task automatic set_async(input logic v);
      @(posedge mclk_in);
      async_hold <= v;
      ctl_out.wen_n <= ~v;
      ctl_out.ren_n <= ~v;
   endtask
   task automatic mrst();
      @(posedge mclk_in);
      ctl_out.master_reset_n <= 1'b0;
      repeat (8) @(posedge mclk_in);
      ctl_out.master_reset_n <= 1'b1;
      repeat (6) @(posedge mclk_in);
   endtask
endmodule // fifo_host_model

// ### dual_clock_fifo_port_control_tb_top.sv
// Self-checking bench for the dual-clock FIFO port control block
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module dual_clock_fifo_port_control_tb_top;
   import fifo_ctl_pkg::*;
   // Small depth so full is reached quickly
   localparam int DEPTH = 16;
   localparam int AW = 4;
   localparam pin_cfg_t SYNC = 10'h003;
   localparam logic [17:0] HI = 18'h1_2345;
   localparam logic [17:0] LO = 18'h2_6789;
   localparam logic [7:0] SER = 8'h3c;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   pin_cfg_t cfg_in = SYNC;
   pin_cfg_t g;
   pin_ctl_t ctl;
   logic [35:0] din;
   logic [35:0] dout;
   logic oe;
   flags_t fl;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;

   initial forever #20 mclk_in = ~mclk_in;

   dual_clock_fifo_port_control #(.DEPTH(DEPTH), .AW(AW)) dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ctl_in(ctl), .cfg_in(cfg_in),
      .data_in_bus_in(din), .data_out_bus_out(dout), .data_out_oe_out(oe),
      .flags_out(fl));
   fifo_host_model host (.mclk_in(mclk_in), .ctl_out(ctl), .data_out(din));

   function automatic logic [35:0] pat(input int i);
      return 36'h9_a5c3_0000 + 36'(i);
   endfunction

   task automatic give_verdict();
      $display("Comparisons: %0d, failures: %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic start(input pin_cfg_t c, input logic ft, input logic ld);
      @(posedge mclk_in);
      cfg_in <= c;
      host.set_misc(1'b0, ld, 1'b1, ft);
      host.mrst();
   endtask

   // Whole run is well under this many clocks
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         failures++;
         give_verdict();
      end
   end

   initial begin
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      // Standard mode, x36
      start(SYNC, 1'b0, 1'b1);
      `CHK(fl.full_flag_n, 1'b1)
      `CHK(fl.empty_flag_n, 1'b0)
      @(posedge mclk_in);
      cfg_in <= '0;
      host.pulse(1, 1, pat(99));
      repeat (3) host.pulse(0, 1, '0);
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(1, 0, pat(50));
      host.pulse(0, 1, '0);
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(0, 1, '0);
      `CHK(fl.empty_flag_n, 1'b1)
      `CHK(dout, 36'h0_0000_0000)
      host.pulse(0, 0, '0);
      `CHK(dout, pat(50))
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(0, 0, '0);
      `CHK(dout, pat(50))
      for (int i = 0; i < DEPTH; i++) host.pulse(1, 0, pat(i));
      `CHK(fl.full_flag_n, 1'b0)
      `CHK(fl.half_full_flag_n, 1'b0)
      `CHK(fl.almost_full_flag_n, 1'b0)
      `CHK(fl.almost_empty_flag_n, 1'b1)
      host.pulse(1, 0, pat(77));
      repeat (2) host.pulse(0, 1, '0);
      host.pulse(0, 0, '0);
      `CHK(dout, pat(0))
      `CHK(fl.full_flag_n, 1'b0)
      host.pulse(1, 1, '0);
      `CHK(fl.full_flag_n, 1'b0)
      host.pulse(1, 1, '0);
      `CHK(fl.full_flag_n, 1'b1)
      for (int i = 1; i < DEPTH; i++) begin
         host.pulse(0, 0, '0);
         `CHK(dout, pat(i))
      end
      `CHK(fl.empty_flag_n, 1'b0)
      `CHK(fl.half_full_flag_n, 1'b1)
      `CHK(fl.almost_full_flag_n, 1'b1)
      `CHK(fl.almost_empty_flag_n, 1'b0)
      // Fall-through mode
      start(SYNC, 1'b1, 1'b1);
      `CHK(fl.full_flag_n, 1'b0)
      `CHK(fl.empty_flag_n, 1'b1)
      host.pulse(1, 0, pat(60));
      repeat (2) host.pulse(0, 1, '0);
      `CHK(dout, 36'h0_0000_0000)
      host.pulse(0, 1, '0);
      `CHK(dout, pat(60))
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(1, 0, pat(61));
      repeat (3) host.pulse(0, 1, '0);
      `CHK(dout, pat(60))
      host.pulse(0, 0, '0);
      `CHK(dout, pat(61))
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(0, 0, '0);
      `CHK(fl.empty_flag_n, 1'b1)
      `CHK(dout, pat(61))
      for (int i = 0; i < DEPTH; i++) host.pulse(1, 0, pat(i));
      `CHK(fl.full_flag_n, 1'b1)
      // x36 in, x18 out, both byte orders
      for (int be = 0; be < 2; be++) begin
         g = SYNC;
         g.bus_match_select = 1'b1;
         g.byte_order_select = be[0];
         // Little-endian pass also runs synchronous flag timing
         g.prog_flag_timing_mode = be[0];
         start(g, 1'b0, 1'b1);
         host.pulse(1, 0, {HI, LO});
         host.pulse(1, 0, {LO, HI});
         repeat (2) host.pulse(0, 1, '0);
         host.pulse(0, 0, '0);
         `CHK(dout[17:0], be ? LO : HI)
         host.pulse(0, 0, '0);
         `CHK(dout[17:0], be ? HI : LO)
         host.pulse(0, 0, '0);
         `CHK(dout[17:0], be ? HI : LO)
         host.pulse(0, 0, '0);
         `CHK(dout[17:0], be ? LO : HI)
         `CHK(fl.almost_full_flag_n, ~be[0])
      end
      // x18 in, x36 out; upper input lanes must be masked
      g = SYNC;
      g.bus_match_select = 1'b1;
      g.input_width_sel = 1'b1;
      start(g, 1'b0, 1'b1);
      host.pulse(1, 0, {LO, HI});
      host.pulse(1, 0, {HI, LO});
      repeat (2) host.pulse(0, 1, '0);
      host.pulse(0, 0, '0);
      `CHK(dout, {HI, LO})
      // Async ports; fall-through request must be overridden
      host.set_async(1'b1);
      g = SYNC;
      g.async_write_select_n = 1'b0;
      g.async_read_select_n = 1'b0;
      start(g, 1'b1, 1'b1);
      `CHK(fl.empty_flag_n, 1'b0)
      host.pulse(1, 1, pat(70));
      repeat (3) host.pulse(0, 1, '0);
      `CHK(dout, pat(70))
      host.set_async(1'b0);
      host.set_misc(1'b1, 1'b1, 1'b1, 1'b0);
      repeat (8) @(posedge mclk_in);
      `CHK(oe, 1'b0)
      host.set_misc(1'b0, 1'b1, 1'b1, 1'b0);
      repeat (8) @(posedge mclk_in);
      `CHK(oe, 1'b1)
      // Parallel offsets: default, then written values
      start(SYNC, 1'b0, 1'b0);
      host.set_misc(1'b0, 1'b0, 1'b1, 1'b0);
      repeat (2) begin
         host.pulse(0, 0, '0);
         `CHK(dout[3:0], 4'h7)
      end
      host.pulse(1, 0, 36'h0_0000_0005);
      host.pulse(1, 0, 36'h0_0000_0009);
      host.pulse(0, 0, '0);
      `CHK(dout[3:0], 4'h5)
      host.pulse(0, 0, '0);
      `CHK(dout[3:0], 4'h9)
      // Serial offsets, MSB first; a disabled edge must not shift
      start(SYNC, 1'b0, 1'b1);
      for (int i = 7; i >= 0; i--) begin
         host.set_misc(1'b0, 1'b0, 1'b0, SER[i]);
         host.pulse(1, 1, '0);
      end
      host.set_misc(1'b0, 1'b0, 1'b1, 1'b1);
      host.pulse(1, 1, '0);
      host.pulse(0, 0, '0);
      `CHK(dout[3:0], 4'h3)
      host.pulse(0, 0, '0);
      `CHK(dout[3:0], 4'hc)
      give_verdict();
   end
endmodule // dual_clock_fifo_port_control_tb_top
